// *** hdl/rtce_pkg.sv ***
// package: constants for the tag command extension logic
package rtce_pkg;
  localparam logic [7:0] BW_OPCODE = 8'hc7;
  localparam logic [7:0] LOCK_OPCODE = 8'hc5;
  localparam int LOCK_LEN_BITS = 60;
  localparam logic [19:0] LOCK_ALL_PAYLOAD = 20'hfffff;
  localparam logic [15:0] MV_OPCODE = 16'he001;
  localparam int MV_MIN_LEN_BITS = 67;
  localparam logic [7:0] ERR_OTHER = 8'h00;
  localparam logic [7:0] ERR_POWER = 8'h0b;
  localparam logic [1:0] BANK_RESERVED = 2'h0;
  localparam logic [1:0] BANK_IDENT = 2'h1;
  localparam logic [1:0] BANK_TID = 2'h2;
  localparam logic [1:0] BANK_USER = 2'h3;
  localparam int SERIAL_LO = 48;
  localparam int SERIAL_HI = 95;
  localparam int WORD_PTR_W = 8;
  typedef enum logic [2:0] {
    RTCE_ST_READY, RTCE_ST_ARBITRATE, RTCE_ST_REPLY, RTCE_ST_ACK, RTCE_ST_OPEN, RTCE_ST_SECURED
  } rtce_tag_state_t;
  typedef enum logic [2:0] {
    RTCE_RSP_NONE, RTCE_RSP_OK_HANDLE, RTCE_RSP_ERROR, RTCE_RSP_WRITE
  } rtce_rsp_kind_t;
endpackage

// *** hdl/rtce_cmd.sv ***
// module: tag-side command extensions (block write, lock, margin verify, id options)
// Function
// - execute one-word block writes, two-word only with even pointer
// - two-word block write with odd pointer: no write, reply error code
// - block write over two words: error reply, no write
// - block write with zero words gets no reply
// - lock command reduced to a single lock bit
// - power-up memory check sets weak-memory flag on weak bit
// - weak flag set: singulation reports zero-length identifier
// - 48-bit serial portion of identification memory has even parity
// - decode margin-verify: 16-bit opcode, at least 67 bits total
// - margin-verify acted on only in open or secured state
// - margin-verify with mismatched handle is silently ignored
// - too little power for margin check: insufficient-power error
// - other error if bad margin or mask differs from stored bit
// - margin check only on programmable banks, not identification memory
// - fields: bank, bit pointer, length, mask, handle, crc
// - bank codes: 00 reserved, 01 identifier, 10 identification, 11 user
// - mask length 1-255; zero length command ignored
// - compare every stored bit against mask bit under margin read
// - pass reply: header 0, handle, crc; preamble from query flag
// - read-suppress mode keeps session-1 flag in B while refreshed
// - combined-id mode returns identifier plus identification; zero length: only latter
module rtce_cmd #(
  parameter int MEM_AW = 9
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // decoded command from the air-link front end
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_opcode_i,
  input wire logic [9:0] cmd_len_bits_i,
  input wire logic [rtce_pkg::WORD_PTR_W-1:0] bw_word_ptr_i,
  input wire logic [7:0] bw_word_count_i,
  input wire logic [19:0] lock_payload_i,
  input wire logic [1:0] mv_bank_i,
  input wire logic [MEM_AW-1:0] mv_bit_ptr_i,
  input wire logic [7:0] mv_length_i,
  input wire logic [255:0] mv_mask_i,
  input wire logic [15:0] mv_handle_i,
  // tag context
  input wire logic [2:0] tag_state_i,
  input wire logic [15:0] tag_handle_i,
  input wire logic power_ok_i,
  input wire logic query_trext_i,
  input wire logic s1_refresh_i,
  input wire logic read_suppress_mode_i,
  input wire logic combined_id_inventory_mode_i,
  input wire logic [4:0] id_word_len_i,
  // memory self-check at power-up
  input wire logic selfcheck_done_i,
  input wire logic selfcheck_weak_i,
  // margin-read memory port
  output logic mem_rd_o,
  output logic [1:0] mem_bank_o,
  output logic [MEM_AW-1:0] mem_addr_o,
  input wire logic mem_bit_i,
  input wire logic mem_margin_ok_i,
  // block write and lock actions
  output logic wr_en_o,
  output logic [rtce_pkg::WORD_PTR_W-1:0] wr_ptr_o,
  output logic [1:0] wr_words_o,
  output logic lock_bit_o,
  // reply request to the backscatter encoder
  output logic rsp_valid_o,
  output logic [2:0] rsp_kind_o,
  output logic [7:0] rsp_err_o,
  output logic [15:0] rsp_handle_o,
  output logic rsp_trext_o,
  // inventory view
  output logic weak_flag_o,
  output logic [4:0] inv_id_len_o,
  output logic inv_send_ident_o,
  output logic inv_send_tid_o,
  output logic s1_flag_b_o,
  output logic serial_parity_ok_o,
  input wire logic [47:0] serial_i
);
  typedef enum {MV_IDLE, MV_READ, MV_DONE} rtce_mv_t;
  rtce_mv_t mv_r;
  logic [7:0] mv_cnt_r;
  logic [7:0] mv_len_r;
  logic [MEM_AW-1:0] mv_addr_r;
  logic [1:0] mv_bank_r;
  logic [255:0] mv_mask_r;
  logic mv_fail_r;
  logic weak_r;
  logic s1_b_r;
  logic lock_r;
  logic [4:0] inv_id_len_r;
  logic inv_ident_r;
  logic inv_tid_r;
  logic parity_r;

  wire logic is_bw = cmd_valid_i && cmd_opcode_i[15:8] == rtce_pkg::BW_OPCODE;
  wire logic is_lock = cmd_valid_i && cmd_opcode_i[15:8] == rtce_pkg::LOCK_OPCODE
    && cmd_len_bits_i == 10'(rtce_pkg::LOCK_LEN_BITS);
  wire logic is_mv = cmd_valid_i && cmd_opcode_i == rtce_pkg::MV_OPCODE
    && cmd_len_bits_i >= 10'(rtce_pkg::MV_MIN_LEN_BITS);
  wire logic mv_state_ok = tag_state_i == 3'(rtce_pkg::RTCE_ST_OPEN)
    || tag_state_i == 3'(rtce_pkg::RTCE_ST_SECURED);
  wire logic mv_take = is_mv && mv_state_ok && mv_handle_i == tag_handle_i
    && mv_length_i != 8'h00 && mv_r == MV_IDLE;
  wire logic mv_prog_bank = mv_bank_i != rtce_pkg::BANK_TID;
  wire logic bw_zero = bw_word_count_i == 8'h00;
  wire logic bw_one = bw_word_count_i == 8'h01;
  wire logic bw_two_ok = bw_word_count_i == 8'h02 && !bw_word_ptr_i[0];
  wire logic bw_err = !bw_zero && !bw_one && !bw_two_ok;
  wire logic bw_go = is_bw && (bw_one || bw_two_ok);
  wire logic mv_bit_bad = mem_bit_i != mv_mask_r[mv_cnt_r] || !mem_margin_ok_i;

  // margin-verify walk, one stored bit every two cycles (read, then compare)
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mv_r <= MV_IDLE;
      mv_cnt_r <= 8'h00;
      mv_len_r <= 8'h00;
      mv_addr_r <= '0;
      mv_bank_r <= 2'h0;
      mv_mask_r <= '0;
      mv_fail_r <= 1'b0;
    end else begin
      unique case (mv_r)
        MV_IDLE: begin
          if (mv_take && power_ok_i && mv_prog_bank) begin
            mv_r <= MV_READ;
            mv_cnt_r <= 8'h00;
            mv_len_r <= mv_length_i;
            mv_addr_r <= mv_bit_ptr_i;
            mv_bank_r <= mv_bank_i;
            mv_mask_r <= mv_mask_i;
            mv_fail_r <= 1'b0;
          end
        end
        MV_READ: begin
          // memory answers one cycle after the read strobe
          mv_r <= MV_DONE;
        end
        MV_DONE: begin
          if (mv_bit_bad) mv_fail_r <= 1'b1;
          if (mv_cnt_r + 8'h01 == mv_len_r) begin
            mv_r <= MV_IDLE;
          end else begin
            mv_cnt_r <= mv_cnt_r + 8'h01;
            mv_addr_r <= mv_addr_r + MEM_AW'(1);
            mv_r <= MV_READ;
          end
        end
      endcase
    end
  end

  wire logic mv_last = mv_r == MV_DONE && mv_cnt_r + 8'h01 == mv_len_r;
  wire logic mv_fail_now = mv_fail_r || mv_bit_bad;
  assign mem_rd_o = mv_r == MV_READ;
  assign mem_bank_o = mv_bank_r;
  assign mem_addr_o = mv_addr_r;

  // reply selection, decoded here so the clocked blocks stay short
  wire logic bw_err_hit = is_bw && bw_err;
  wire logic early_hit = bw_go || bw_err_hit || is_lock;
  wire logic mv_pwr_hit = mv_take && !power_ok_i;
  // identification bank is read-only, so the check is refused outright
  wire logic mv_bank_hit = mv_take && power_ok_i && !mv_prog_bank;
  wire logic mv_end_hit = !early_hit && mv_last;
  wire logic mv_pass_hit = mv_end_hit && !mv_fail_now;
  wire logic rsp_fire = bw_err_hit || mv_pwr_hit || mv_bank_hit || mv_end_hit;
  wire logic [2:0] rsp_kind_nxt = mv_pass_hit ? 3'(rtce_pkg::RTCE_RSP_OK_HANDLE)
    : 3'(rtce_pkg::RTCE_RSP_ERROR);
  wire logic [7:0] rsp_err_nxt = mv_pwr_hit ? rtce_pkg::ERR_POWER : rtce_pkg::ERR_OTHER;
  // single lock bit: all ones locks everything until reset
  wire logic lock_all = is_lock && lock_payload_i == rtce_pkg::LOCK_ALL_PAYLOAD;
  wire logic lock_nxt = lock_r || lock_all;

  // reply strobe, one cycle wide
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
    end else begin
      rsp_valid_o <= rsp_fire;
    end
  end

  // reply kind holds until the next reply
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rsp_kind_o <= 3'(rtce_pkg::RTCE_RSP_NONE);
    end else if (rsp_fire) begin
      rsp_kind_o <= rsp_kind_nxt;
    end
  end

  // error code holds as well, so a late reader still sees it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rsp_err_o <= 8'h00;
    end else if (rsp_fire) begin
      rsp_err_o <= rsp_err_nxt;
    end
  end

  // handle and preamble follow the round, not the command
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rsp_handle_o <= 16'h0000;
      rsp_trext_o <= 1'b0;
    end else begin
      rsp_handle_o <= tag_handle_i;
      rsp_trext_o <= query_trext_i;
    end
  end

  // block write strobe; the array does the word programming
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_en_o <= 1'b0;
    end else begin
      wr_en_o <= bw_go;
    end
  end

  // write target holds after the strobe for the array's sake
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr_o <= '0;
      wr_words_o <= 2'h0;
    end else if (bw_go) begin
      wr_ptr_o <= bw_word_ptr_i;
      wr_words_o <= bw_word_count_i[1:0];
    end
  end

  // lock bit survives every command until reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
    end
  end
  assign lock_bit_o = lock_r;

  // power-up self-check result and session-1 flag
  wire logic weak_nxt = weak_r || (selfcheck_done_i && selfcheck_weak_i);
  // without suppress mode the flag is cleared on the next clock
  wire logic s1_b_nxt = read_suppress_mode_i && (s1_refresh_i || s1_b_r);

  // weak flag sticks until next power-up reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      weak_r <= 1'b0;
    end else begin
      weak_r <= weak_nxt;
    end
  end

  // refresh keeps B only while suppress mode is on
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s1_b_r <= 1'b0;
    end else begin
      s1_b_r <= s1_b_nxt;
    end
  end
  assign weak_flag_o = weak_r;
  assign s1_flag_b_o = s1_b_r;

  // inventory view; weak_nxt keeps the length in step with the flag
  wire logic [4:0] inv_id_len_nxt = weak_nxt ? 5'h00 : id_word_len_i;
  wire logic inv_ident_nxt = !weak_nxt && id_word_len_i != 5'h00;
  wire logic inv_tid_nxt = combined_id_inventory_mode_i;
  wire logic parity_nxt = ~^serial_i;

  // identifier part of the inventory reply
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      inv_id_len_r <= 5'h00;
      inv_ident_r <= 1'b0;
    end else begin
      inv_id_len_r <= inv_id_len_nxt;
      inv_ident_r <= inv_ident_nxt;
    end
  end

  // identification part and its parity; one cycle late, reloaded every clock
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      inv_tid_r <= 1'b0;
      parity_r <= 1'b0;
    end else begin
      inv_tid_r <= inv_tid_nxt;
      parity_r <= parity_nxt;
    end
  end
  assign inv_id_len_o = inv_id_len_r;
  assign inv_send_ident_o = inv_ident_r;
  assign inv_send_tid_o = inv_tid_r;
  assign serial_parity_ok_o = parity_r;
endmodule // rtce_cmd

// *** verif/rtce_cmd_props.sv ***
// checker: port-level properties of the tag command logic
module rtce_cmd_props #(parameter int MEM_AW = 9) (
  // watched ports
  input wire logic clock_i, reset_i, cmd_valid_i, power_ok_i, query_trext_i, weak_flag_o,
  input wire logic mem_rd_o, wr_en_o, rsp_valid_o, lock_bit_o, serial_parity_ok_o, rsp_trext_o,
  input wire logic [15:0] cmd_opcode_i, mv_handle_i, tag_handle_i, rsp_handle_o,
  input wire logic [7:0] bw_word_count_i, bw_word_ptr_i, wr_ptr_o, mv_length_i, rsp_err_o,
  input wire logic [19:0] lock_payload_i,
  input wire logic [2:0] tag_state_i, rsp_kind_o,
  input wire logic [1:0] mv_bank_i, wr_words_o, mem_bank_o,
  input wire logic [9:0] cmd_len_bits_i,
  input wire logic [MEM_AW-1:0] mv_bit_ptr_i, mem_addr_o,
  input wire logic [4:0] inv_id_len_o,
  input wire logic [47:0] serial_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire bw = cmd_valid_i && cmd_opcode_i[15:8] == rtce_pkg::BW_OPCODE;
  wire mvc = cmd_valid_i && cmd_opcode_i == rtce_pkg::MV_OPCODE;
  wire mv = mvc && mv_length_i != 8'h00 && mv_handle_i == tag_handle_i && tag_state_i[2];
  // refused commands must leave every strobe low for a while
  sequence quiet;
    (!rsp_valid_o && !wr_en_o && !mem_rd_o) [*3];
  endsequence
  a_bw_zero_silent: assert property (bw && bw_word_count_i == 8'h00 |=> quiet)
    else $error("zero-word block write answered");
  a_bw_single_write: assert property (bw && bw_word_count_i == 8'h01 |=> wr_en_o &&
    wr_words_o == 2'h1 && wr_ptr_o == $past(bw_word_ptr_i)) else $error("one-word write lost");
  a_bw_odd_err: assert property (bw && bw_word_count_i == 8'h02 && bw_word_ptr_i[0] |=>
    rsp_valid_o && rsp_kind_o == 3'h2 && rsp_err_o == rtce_pkg::ERR_OTHER && !wr_en_o)
    else $error("odd two-word write not refused");
  a_bw_long_err: assert property (bw && bw_word_count_i > 8'h02 |=> rsp_valid_o &&
    rsp_kind_o == 3'h2 && !wr_en_o) else $error("long block write not refused");
  a_lock_all_ones: assert property (cmd_valid_i && cmd_opcode_i[15:8] == rtce_pkg::LOCK_OPCODE
    && cmd_len_bits_i == 10'(rtce_pkg::LOCK_LEN_BITS)
    && lock_payload_i == rtce_pkg::LOCK_ALL_PAYLOAD |=> lock_bit_o) else $error("lock missed");
  a_mv_refused: assert property (mvc && !mv |=> quiet)
    else $error("refused margin verify answered");
  a_mv_power_err: assert property (mv && !power_ok_i |=> rsp_valid_o &&
    rsp_err_o == rtce_pkg::ERR_POWER) else $error("low power not reported");
  a_mv_walk_start: assert property (mv && power_ok_i && mv_bank_i == rtce_pkg::BANK_USER |=>
    mem_rd_o && mem_addr_o == $past(mv_bit_ptr_i) && mem_bank_o == rtce_pkg::BANK_USER
    ##1 !rsp_valid_o)
    else $error("walk start wrong");
  a_pass_reply: assert property (rsp_valid_o && rsp_kind_o == 3'h1 |-> rsp_handle_o ==
    tag_handle_i && rsp_trext_o == query_trext_i) else $error("pass reply fields");
  a_weak_zero_len: assert property (weak_flag_o |-> inv_id_len_o == 5'h00)
    else $error("weak tag shows identifier");
  a_serial_parity: assert property (!$past(reset_i) |->
    serial_parity_ok_o == !(^$past(serial_i)))
    else $error("serial parity flag wrong");
endmodule // rtce_cmd_props
bind rtce_cmd rtce_cmd_props #(.MEM_AW(MEM_AW)) u_props (.*);

// *** verif/rtce_mem_model.sv ***
// partner: margin-read memory with one settable weak cell
module rtce_mem_model #(parameter int MEM_AW = 9) (
  // read port
  input wire logic clock_i,
  input wire logic rd_i,
  input wire logic [MEM_AW-1:0] addr_i,
  input wire logic weak_en_i,
  input wire logic [MEM_AW-1:0] weak_addr_i,
  output logic bit_o,
  output logic ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bit_o = 1'b0;
  initial ok_o = 1'b0;
  // idle cycles toggle so a stale sample never looks valid
  always @(posedge clock_i) begin
    bit_o <= rd_i ? addr_i[0] ^ addr_i[3] : !bit_o;
    ok_o <= rd_i ? !(weak_en_i && addr_i == weak_addr_i) : !ok_o;
  end
endmodule // rtce_mem_model

// *** verif/rtce_cmd_tb_top.sv ***
// testbench: random and corner commands against the tag command logic
module rtce_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, reset_i = 1, cmd_valid_i = 0, power_ok_i = 1, query_trext_i = 1, weak_en = 0;
  logic s1_refresh_i = 0, read_suppress_mode_i = 0, combined_id_inventory_mode_i = 0;
  logic selfcheck_done_i = 0, selfcheck_weak_i = 0, mem_bit_i, mem_margin_ok_i, mem_rd_o;
  logic wr_en_o, lock_bit_o, rsp_valid_o, rsp_trext_o, weak_flag_o, inv_send_ident_o;
  logic inv_send_tid_o, s1_flag_b_o, serial_parity_ok_o;
  logic [15:0] cmd_opcode_i = 0, mv_handle_i = 0, tag_handle_i = 16'h5a3c, rsp_handle_o;
  logic [9:0] cmd_len_bits_i = 10'h03a;
  logic [7:0] bw_word_ptr_i = 0, bw_word_count_i = 0, mv_length_i = 0, wr_ptr_o, rsp_err_o;
  logic [19:0] lock_payload_i = 0;
  logic [1:0] mv_bank_i = 2'h3, mem_bank_o, wr_words_o;
  logic [8:0] mv_bit_ptr_i = 0, mem_addr_o, weak_addr = 0;
  logic [255:0] mv_mask_i = 0;
  logic [2:0] tag_state_i = 3'h4, rsp_kind_o, e;
  logic [4:0] id_word_len_i = 5'h06, inv_id_len_o;
  logic [47:0] serial_i = 0;
  logic [31:0] seed = 32'hdcfc;
  int errors = 0, tests_run = 0, cyc = 0, got, lat;
  rtce_cmd #(.MEM_AW(9)) DUT (.*);
  rtce_mem_model #(.MEM_AW(9)) u_mem (.clock_i(clock_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
    .weak_en_i(weak_en), .weak_addr_i(weak_addr), .bit_o(mem_bit_i), .ok_o(mem_margin_ok_i));
  always #12.5 clock_i = ~clock_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected outcome of a block write: 0 silent, 2 error, 3 write
  function automatic logic [2:0] bw_exp(input logic [7:0] n, input logic p0);
    if (n == 8'h00) return 3'h0;
    return (n == 8'h01 || (n == 8'h02 && !p0)) ? 3'h3 : 3'h2;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang costs far more than the longest walk of 510 cycles per command
  always @(posedge clock_i) if (++cyc == 40000) begin errors++; tally_and_finish(); end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    tests_run++;
    if (x !== s) begin errors++; $display("mismatch %s expected %h seen %h", n, x, s); end
  endtask
  task automatic send(input logic [15:0] op);
    @(negedge clock_i); cmd_opcode_i = op; cmd_valid_i = 1;
    @(negedge clock_i); cmd_valid_i = 0; got = 0; lat = 0;
    while (!got && lat < 520)
      if (rsp_valid_o === 1'b1 || wr_en_o === 1'b1) got = 1; else begin @(negedge clock_i); lat++; end
  endtask
  task automatic mv(input logic [2:0] st, input logic [15:0] h, input logic [7:0] n,
    input logic flip, input logic pw, input logic [2:0] ek, input logic [7:0] ee);
    tag_state_i = st; mv_handle_i = h; mv_length_i = n; power_ok_i = pw;
    mv_bit_ptr_i = {1'b0, seed[7:0]}; cmd_len_bits_i = 10'(66 + n);
    for (int k = 0; k < 256; k++) mv_mask_i[k] = ^((mv_bit_ptr_i + 9'(k)) & 9'h009);
    mv_mask_i[0] ^= flip;
    send(rtce_pkg::MV_OPCODE);
    chk("mv kind", ek, got ? rsp_kind_o : 3'h0);
    if (ek == 3'h1) chk("mv lat", 2 * n, lat);
    if (ek == 3'h1) chk("mv handle", tag_handle_i, rsp_handle_o);
    if (ek == 3'h2) chk("mv err", ee, rsp_err_o);
    seed = lfsr(seed);
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    @(negedge clock_i); reset_i = 0;
    for (int i = 0; i < 20; i++) begin
      bw_word_count_i = (i < 5) ? 8'(i) : (i == 5) ? 8'h02 : {6'h00, seed[1:0]};
      bw_word_ptr_i = {seed[7:1], (i < 5) ? i[0] : (i == 5) ? 1'b1 : seed[0]};
      e = bw_exp(bw_word_count_i, bw_word_ptr_i[0]);
      send({rtce_pkg::BW_OPCODE, 8'h00});
      chk("bw kind", e, got ? (wr_en_o ? 3'h3 : rsp_kind_o) : 3'h0);
      if (e == 3'h3) chk("bw ptr", {bw_word_ptr_i, bw_word_count_i}, {wr_ptr_o, 6'h0, wr_words_o});
      if (e == 3'h2) chk("bw err", rtce_pkg::ERR_OTHER, rsp_err_o);
      seed = lfsr(seed);
    end
    cmd_len_bits_i = 10'h03c; lock_payload_i = 20'h0f0f0;
    send({rtce_pkg::LOCK_OPCODE, 8'h00});
    chk("lock bit", 0, lock_bit_o);
    lock_payload_i = rtce_pkg::LOCK_ALL_PAYLOAD;
    send({rtce_pkg::LOCK_OPCODE, 8'h00});
    chk("lock bit", 1, lock_bit_o);
    mv(3'h4, tag_handle_i, 8'h01, 0, 1, 3'h1, 0);
    for (int j = 0; j < 4; j++) mv(3'h5, tag_handle_i, {4'h0, seed[11:8]} + 8'h01, 0, 1, 3'h1, 0);
    mv(3'h4, tag_handle_i, 8'hff, 0, 1, 3'h1, 0);
    mv(3'h4, tag_handle_i, 8'h09, 1, 1, 3'h2, rtce_pkg::ERR_OTHER);
    weak_en = 1; weak_addr = {1'b0, seed[7:0]};
    mv(3'h5, tag_handle_i, 8'h04, 0, 1, 3'h2, rtce_pkg::ERR_OTHER);
    weak_en = 0;
    mv(3'h3, tag_handle_i, 8'h04, 0, 1, 3'h0, 0);
    mv(3'h0, tag_handle_i, 8'h04, 0, 1, 3'h0, 0);
    mv(3'h4, ~tag_handle_i, 8'h04, 0, 1, 3'h0, 0);
    mv(3'h4, tag_handle_i, 8'h00, 0, 1, 3'h0, 0);
    mv(3'h4, tag_handle_i, 8'h04, 0, 0, 3'h2, rtce_pkg::ERR_POWER);
    mv_bank_i = rtce_pkg::BANK_TID;
    mv(3'h4, tag_handle_i, 8'h04, 0, 1, 3'h2, rtce_pkg::ERR_OTHER);
    power_ok_i = 1; combined_id_inventory_mode_i = 1; id_word_len_i = 0;
    @(negedge clock_i) chk("inv parts", 2'b01, {inv_send_ident_o, inv_send_tid_o});
    id_word_len_i = 5'h06;
    @(negedge clock_i) chk("inv parts", 2'b11, {inv_send_ident_o, inv_send_tid_o});
    read_suppress_mode_i = 1; s1_refresh_i = 1;
    @(negedge clock_i) s1_refresh_i = 0;
    @(negedge clock_i) chk("s1 b", 1, s1_flag_b_o);
    for (int j = 0; j < 8; j++) begin
      serial_i = {seed[15:0], seed}; seed = lfsr(seed);
      @(negedge clock_i) chk("parity", !(^serial_i), serial_parity_ok_o);
    end
    selfcheck_weak_i = 1; selfcheck_done_i = 1;
    repeat (3) @(negedge clock_i);
    chk("weak flag", 1, weak_flag_o);
    chk("id len", 0, inv_id_len_o);
    tally_and_finish();
  end
endmodule // rtce_cmd_tb_top
